// ==== bench/eeprom_model.sv ====
`timescale 1ns/10ps
module eeprom_model
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // word fetch port
  input wire logic rd_req_in,
  input wire logic [7:0] addr_in,
  input wire logic [3:0] lag_in,
  output logic rd_ack_out,
  output logic [15:0] data_out
);
  logic [15:0] mem [0:255];
  logic [3:0] wait_cnt;
  // data toggles outside the ack cycle so a stale word never looks valid
  always_ff @(posedge ref_clk_in)
  begin
    rd_ack_out <= 1'b0;
    data_out <= ~data_out;
    if (!nrst_in)
    begin
      wait_cnt <= 4'h0;
      data_out <= 16'h5A5A;
    end
    else if (rd_req_in && !rd_ack_out)
    begin
      if (wait_cnt >= lag_in)
      begin
        rd_ack_out <= 1'b1;
        data_out <= mem[addr_in];
        wait_cnt <= 4'h0;
      end
      else
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : eeprom_model

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top
  import loader_pkg::*;
;
  `define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
  typedef struct packed {
    logic [15:0] info2;
    logic [15:0] info3;
    logic [3:0] flags;
  } row_type;
  // flags: pulse mode, full power on bus reset, line fix, phy code valid
  row_type rows [8] = '{'{16'h0018, 16'h0000, 4'b1001}, '{16'h0010, 16'h0001, 4'b0001},
    '{16'h0008, 16'h0002, 4'b0001}, '{16'h0080, 16'h0003, 4'b0101},
    '{16'h0020, 16'h0004, 4'b0011}, '{16'h00B8, 16'h0005, 4'b1111},
    '{16'h0000, 16'h0006, 4'b0000}, '{16'hFF47, 16'hFFFF, 4'b0000}};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pbr = 1'b0;
  logic [6:0] smb_addr = 7'h00;
  logic smb_valid = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [31:0] prdata, core, rq;
  logic pready, pslverr, ee_req, ee_ack, match, done, pulse, full, liw, phy_ok, re;
  logic [7:0] ee_addr;
  logic [15:0] ee_data, mask, vendor, model;
  logic [3:0] phy;
  logic [1:0] pwr;
  int bad_count = 0;
  int tests_run = 0;
  always #2.5 clk = ~clk;
  eeprom_config_word_loader DUT (.ref_clk_in(clk), .nrst_in(nrst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .ee_rd_req_out(ee_req), .ee_addr_out(ee_addr), .ee_rd_ack_in(ee_ack),
    .ee_data_in(ee_data), .pci_bus_reset_in(pbr), .smb_addr_in(smb_addr),
    .smb_addr_valid_in(smb_valid), .smb_addr_match_out(match), .load_done_out(done),
    .core_setup_word_out(core), .transceiver_option_mask_out(mask),
    .board_vendor_code_out(vendor), .board_model_code_out(model),
    .wake_signal_pulse_mode_out(pulse), .bus_reset_full_power_out(full),
    .line_invalidate_write_fixed_out(liw), .forced_phy_type_out(phy),
    .forced_phy_valid_out(phy_ok), .power_state_out(pwr));
  eeprom_model EE (.ref_clk_in(clk), .nrst_in(nrst), .rd_req_in(ee_req), .addr_in(ee_addr),
    .lag_in(lag), .rd_ack_out(ee_ack), .data_out(ee_data));
  task automatic conclude();
    $display("counts: %0d checks, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rq, re);
    `CHK(rq, exp)
    `CHK(re, 1'b0)
  endtask : rd_chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rq, re);
  endtask : wr
  task automatic smb(input logic [6:0] a, input logic exp);
    smb_addr <= a;
    smb_valid <= 1'b1;
    @(posedge clk);
    smb_valid <= 1'b0;
    @(negedge clk);
    `CHK(match, exp)
    @(posedge clk);
  endtask : smb
  task automatic do_reset(input logic [3:0] lag_v);
    nrst <= 1'b0;
    lag <= lag_v;
    repeat (10) @(posedge clk);
    `CHK({done, core, mask, pwr}, 51'h0)
    `CHK(ee_addr, EE_CORE_LO)
    nrst <= 1'b1;
    @(posedge clk);
  endtask : do_reset
  task automatic wait_load(input logic [31:0] exp_core);
    int n;
    n = 0;
    while (done !== 1'b1 && n < 400)
    begin
      `CHK(core, CORE_DEFAULT)
      @(posedge clk);
      n++;
    end
    `CHK(core, exp_core)
  endtask : wait_load
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    conclude();
  end
  initial
  begin
    // vendor and model values are arbitrary
    EE.mem[EE_CORE_LO] = 16'h1234;
    EE.mem[EE_CORE_HI] = 16'hABCD;
    EE.mem[EE_VENDOR] = 16'h0F0E;
    EE.mem[EE_MODEL] = 16'h2A07;
    EE.mem[EE_MEDIA] = 16'h005C;
    EE.mem[EE_SLAVE] = 16'h0053;
    for (int i = 0; i < 8; i++)
    begin
      EE.mem[EE_INFO2] = rows[i].info2;
      EE.mem[EE_INFO3] = rows[i].info3;
      do_reset(4'(i % 3));
      wait_load(32'hABCD1234);
      repeat (2) @(posedge clk);
      `CHK({pulse, full, liw, phy_ok}, rows[i].flags)
      `CHK(phy, rows[i].info3[3:0])
      rd_chk(REG_STATUS, {26'h0, rows[i].flags[0], rows[i].flags[1], rows[i].flags[2],
        rows[i].flags[3], rows[i].info2[3], 1'b1});
      rd_chk(REG_INFO2, {16'h0, rows[i].info2});
      rd_chk(REG_INFO3, {16'h0, rows[i].info3});
      wr(REG_POWER, 32'h3);
      pbr <= 1'b1;
      repeat (3) @(posedge clk);
      pbr <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK(pwr, rows[i].flags[2] ? PWR_D0 : 2'h3)
      rd_chk(REG_POWER, {30'h0, (rows[i].flags[2] ? PWR_D0 : 2'h3)});
      $display("test row %0d done", i);
    end
    // slow partner; early writes must not disturb the load
    do_reset(4'h5);
    @(posedge clk);
    wr(REG_CORE, 32'hDEADBEEF);
    wr(REG_MASK, 32'h0000FFFF);
    wait_load(32'hABCD1234);
    `CHK(mask, 16'h005C)
    rd_chk(REG_MASK, 32'h0000005C);
    `CHK({model, vendor}, 32'h2A070F0E)
    rd_chk(REG_BOARD, 32'h2A070F0E);
    rd_chk(REG_SLAVE, 32'h00000053);
    smb(7'h53, 1'b1);
    smb(7'h52, 1'b0);
    $display("test slow load done");
    wr(REG_CORE, 32'hDEADBEEF);
    `CHK(core, 32'hDEADBEEF)
    rd_chk(REG_CORE, 32'hDEADBEEF);
    wr(REG_SLAVE, 32'h00000021);
    smb(7'h21, 1'b1);
    wr(REG_BOARD, 32'h0);
    rd_chk(REG_BOARD, 32'h2A070F0E);
    apb(1'b0, 8'h40, 32'h0, rq, re);
    `CHK(re, 1'b1)
    $display("test host access done");
    conclude();
  end
endmodule : tb_top

// ==== src/config_fetch_seq.sv ====
`timescale 1ns/10ps
module config_fetch_seq
  import loader_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // eeprom word fetch port
  output logic ee_rd_req_out,
  output logic [7:0] ee_addr_out,
  input wire logic ee_rd_ack_in,
  input wire logic [15:0] ee_data_in,
  // fetched words
  output logic [NUM_WORDS*16-1:0] words_out,
  output logic done_out
);
  fetch_state_type state;
  logic [SLOT_W-1:0] slot;
  logic last_slot;

  assign last_slot = (slot == SLOT_W'(NUM_WORDS - 1));
  assign ee_rd_req_out = (state == ST_FETCH);
  assign done_out = (state == ST_FINISH);

  // fetch starts straight out of reset
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
      state <= ST_FETCH; // R2
    else
      case (state)
        ST_FETCH: if (ee_rd_ack_in && last_slot) state <= ST_FINISH;
        ST_FINISH: state <= ST_HOLD;
        ST_HOLD: state <= ST_HOLD;
        default: state <= ST_HOLD;
      endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      slot <= '0;
      ee_addr_out <= EE_CORE_LO;
      words_out <= '0;
    end
    else if (state == ST_FETCH && ee_rd_ack_in)
    begin
      words_out[int'(slot)*16 +: 16] <= ee_data_in;
      if (!last_slot)
      begin
        slot <= slot + SLOT_W'(1);
        ee_addr_out <= ee_word_addr(slot + SLOT_W'(1));
      end
    end
  end

  a_fetch_starts: assert property (@(posedge ref_clk_in) $rose(nrst_in) |-> ee_rd_req_out) // R2
    else $error("fetch not requested after reset");
  a_done_once: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    done_out |=> !done_out [*4]) // R13
    else $error("fetch done pulsed twice");
endmodule : config_fetch_seq

// ==== src/eeprom_config_word_loader.sv ====
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module eeprom_config_word_loader
  import loader_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // eeprom word fetch port
  output logic ee_rd_req_out,
  output logic [7:0] ee_addr_out,
  input wire logic ee_rd_ack_in,
  input wire logic [15:0] ee_data_in,
  // pci bus reset pin
  input wire logic pci_bus_reset_in,
  // sideband address compare
  input wire logic [6:0] smb_addr_in,
  input wire logic smb_addr_valid_in,
  output logic smb_addr_match_out,
  // configuration outputs
  output logic load_done_out,
  output logic [31:0] core_setup_word_out,
  output logic [15:0] transceiver_option_mask_out,
  output logic [15:0] board_vendor_code_out,
  output logic [15:0] board_model_code_out,
  output logic wake_signal_pulse_mode_out,
  output logic bus_reset_full_power_out,
  output logic line_invalidate_write_fixed_out,
  output logic [3:0] forced_phy_type_out,
  output logic forced_phy_valid_out,
  output logic [1:0] power_state_out
);
  logic [NUM_WORDS*16-1:0] words;
  logic fetch_done;
  logic loaded;
  logic [31:0] core_setup_word;
  logic [15:0] transceiver_option_mask;
  logic [6:0] sideband_slave_id;
  logic [15:0] info2;
  logic [15:0] info3;
  logic [15:0] board_vendor_code;
  logic [15:0] board_model_code;
  logic [1:0] power_state;
  logic bus_rst_meta;
  logic bus_rst_sync;
  logic bus_rst_prev;
  logic bus_rst_pulse;
  logic setup_phase;
  logic wr_access;
  logic [31:0] next_rdata;
  logic next_slverr;
  logic aux_wake_header_present;

  function automatic logic [15:0] word_at(input logic [NUM_WORDS*16-1:0] w, input int idx);
    word_at = w[idx*16 +: 16];
  endfunction : word_at

  function automatic logic wr_hit(input logic acc, input logic [7:0] a, input logic [7:0] off);
    wr_hit = acc && (a == off);
  endfunction : wr_hit

  config_fetch_seq u_fetch (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .ee_rd_req_out(ee_rd_req_out),
    .ee_addr_out(ee_addr_out),
    .ee_rd_ack_in(ee_rd_ack_in),
    .ee_data_in(ee_data_in),
    .words_out(words),
    .done_out(fetch_done)
  );

  // apb: read data captured in setup, so every access ends in one access cycle
  assign setup_phase = psel_in && !penable_in;
  assign wr_access = psel_in && penable_in && pwrite_in;
  assign pready_out = psel_in && penable_in;

  // core, mask and slave id writes before the fetch ends are dropped, the fetch would clobber them anyway
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
      loaded <= 1'b0;
    else if (fetch_done)
      loaded <= 1'b1; // R13
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
      core_setup_word <= CORE_DEFAULT; // R13
    else if (fetch_done)
      core_setup_word <= {word_at(words, W_CORE_HI), word_at(words, W_CORE_LO)}; // R1
    else if (loaded && wr_hit(wr_access, paddr_in, REG_CORE))
      core_setup_word <= pwdata_in; // R3
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
      transceiver_option_mask <= MASK_DEFAULT;
    else if (fetch_done)
      transceiver_option_mask <= word_at(words, W_MEDIA); // R4
    else if (loaded && wr_hit(wr_access, paddr_in, REG_MASK))
      transceiver_option_mask <= pwdata_in[15:0];
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
      sideband_slave_id <= SLAVE_DEFAULT;
    else if (fetch_done)
      sideband_slave_id <= SLAVE_W'(word_at(words, W_SLAVE)); // R5
    else if (loaded && wr_hit(wr_access, paddr_in, REG_SLAVE))
      sideband_slave_id <= pwdata_in[SLAVE_W-1:0];
  end

  // driver info and board codes are read only
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      info2 <= WORD_DEFAULT;
      info3 <= WORD_DEFAULT;
      board_vendor_code <= WORD_DEFAULT;
      board_model_code <= WORD_DEFAULT;
    end
    else if (fetch_done)
    begin
      info2 <= word_at(words, W_INFO2);
      info3 <= word_at(words, W_INFO3);
      board_vendor_code <= word_at(words, W_VENDOR); // R10
      board_model_code <= word_at(words, W_MODEL); // R10
    end
  end

  assign aux_wake_header_present = info2[AUX_HDR_BIT];

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      wake_signal_pulse_mode_out <= 1'b0;
      bus_reset_full_power_out <= 1'b0;
      line_invalidate_write_fixed_out <= 1'b0;
      forced_phy_type_out <= '0;
      forced_phy_valid_out <= 1'b0;
    end
    else
    begin
      // pulse mode only counts with the header fitted
      wake_signal_pulse_mode_out <= aux_wake_header_present && info2[PULSE_BIT]; // R6 R7
      bus_reset_full_power_out <= info2[FULL_PWR_BIT]; // R8
      line_invalidate_write_fixed_out <= info2[LIW_FIX_BIT]; // R9
      forced_phy_type_out <= info3[PHY_LSB +: PHY_W]; // R11
      forced_phy_valid_out <= (info3[PHY_LSB +: PHY_W] <= PHY_LAST_CODE); // R11
    end
  end

  // pci reset pin comes from another domain
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      bus_rst_meta <= 1'b0;
      bus_rst_sync <= 1'b0;
      bus_rst_prev <= 1'b0;
    end
    else
    begin
      bus_rst_meta <= pci_bus_reset_in;
      bus_rst_sync <= bus_rst_meta;
      bus_rst_prev <= bus_rst_sync;
    end
  end

  assign bus_rst_pulse = bus_rst_sync && !bus_rst_prev;

  // bus reset with the full power bit set wins over a software write in the same cycle
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
      power_state <= PWR_D0;
    else if (bus_rst_pulse && info2[FULL_PWR_BIT])
      power_state <= PWR_D0; // R8
    else if (wr_hit(wr_access, paddr_in, REG_POWER))
      power_state <= pwdata_in[1:0];
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
      smb_addr_match_out <= 1'b0;
    else
      smb_addr_match_out <= smb_addr_valid_in && (smb_addr_in == sideband_slave_id); // R5
  end

  always_comb
  begin
    next_rdata = '0;
    next_slverr = 1'b0;
    case (paddr_in)
      REG_CORE: next_rdata = core_setup_word;
      REG_MASK: next_rdata[15:0] = transceiver_option_mask;
      REG_SLAVE: next_rdata[SLAVE_W-1:0] = sideband_slave_id;
      REG_INFO2: next_rdata[15:0] = info2;
      REG_INFO3: next_rdata[15:0] = info3;
      REG_BOARD: next_rdata = {board_model_code, board_vendor_code};
      REG_STATUS: next_rdata[5:0] = {forced_phy_valid_out, line_invalidate_write_fixed_out,
        bus_reset_full_power_out, wake_signal_pulse_mode_out, aux_wake_header_present, loaded};
      REG_POWER: next_rdata[1:0] = power_state;
      default: next_slverr = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      prdata_out <= '0;
      pslverr_out <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_out <= pwrite_in ? 32'h0000_0000 : next_rdata;
      pslverr_out <= next_slverr;
    end
  end

  assign load_done_out = loaded;
  assign core_setup_word_out = core_setup_word;
  assign transceiver_option_mask_out = transceiver_option_mask;
  assign board_vendor_code_out = board_vendor_code;
  assign board_model_code_out = board_model_code;
  assign power_state_out = power_state;

  a_core_halves_load: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    fetch_done |=> core_setup_word == {word_at($past(words), W_CORE_HI),
      word_at($past(words), W_CORE_LO)}) // R1
    else $error("core setup halves loaded wrongly");
  a_host_overwrite: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    loaded && !fetch_done && wr_access && paddr_in == REG_CORE
      |=> core_setup_word == $past(pwdata_in)) // R3
    else $error("core setup write lost");
  a_option_mask_load: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    fetch_done |=> transceiver_option_mask == word_at($past(words), W_MEDIA)) // R4
    else $error("option mask not loaded");
  a_slave_id_match: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    smb_addr_valid_in && smb_addr_in == sideband_slave_id && !fetch_done
      && !wr_hit(wr_access, paddr_in, REG_SLAVE) |=> smb_addr_match_out) // R5
    else $error("sideband address not matched");
  a_pulse_mode_sel: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    aux_wake_header_present |=> wake_signal_pulse_mode_out == $past(info2[PULSE_BIT])) // R6
    else $error("wake pulse mode wrong");
  a_pulse_needs_header: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    !aux_wake_header_present |=> !wake_signal_pulse_mode_out) // R7
    else $error("pulse mode without header");
  a_bus_reset_d0: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $rose(bus_rst_sync) && info2[FULL_PWR_BIT] |=> power_state_out == PWR_D0) // R8
    else $error("bus reset did not return to d0");
  a_line_fix_flag: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $rose(loaded) |=> line_invalidate_write_fixed_out == info2[LIW_FIX_BIT]) // R9
    else $error("line invalidate flag wrong");
  a_board_codes: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    fetch_done |=> board_model_code_out[15:8] == $past(words[W_MODEL*16+8 +: 8])) // R10
    else $error("board model code wrong");
  a_phy_code_valid: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $rose(loaded) ##1 1'b1 |-> forced_phy_valid_out == (info3[3:0] <= PHY_LAST_CODE)) // R11
    else $error("forced phy validity wrong");
  a_defaults_held: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    !loaded |-> core_setup_word == CORE_DEFAULT && transceiver_option_mask == MASK_DEFAULT) // R13
    else $error("register left default early");

  // load and hold
  a_slave_id_load: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    fetch_done |=> sideband_slave_id == SLAVE_W'(word_at($past(words), W_SLAVE))) // R5
    else $error("sideband slave id not loaded");
  a_vendor_code: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    fetch_done |=> board_vendor_code_out == word_at($past(words), W_VENDOR)) // R10
    else $error("board vendor code wrong");
  a_model_low_byte: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    fetch_done |=> board_model_code_out[BYTE_W-1:0] == $past(words[W_MODEL*16 +: BYTE_W])) // R10
    else $error("board model revision byte wrong");
  a_load_all_once: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    fetch_done |=> loaded && info2 == word_at($past(words), W_INFO2)
      && info3 == word_at($past(words), W_INFO3)) // R13
    else $error("driver info not loaded with the rest");
  a_early_hold: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    !loaded && !fetch_done
      |=> sideband_slave_id == SLAVE_DEFAULT && info2 == WORD_DEFAULT) // R13
    else $error("register moved before the fetch ended");
  a_loaded_sticky: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    loaded |=> loaded) // R13
    else $error("load done dropped");
  a_info_stable: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    loaded && !fetch_done |=> $stable(info2) && $stable(info3)) // R13
    else $error("driver info changed after load");

  // sideband compare
  a_slave_no_match: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    smb_addr_valid_in && smb_addr_in != sideband_slave_id |=> !smb_addr_match_out) // R5
    else $error("foreign sideband address matched");
  a_slave_host_write: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    loaded && !fetch_done && wr_hit(wr_access, paddr_in, REG_SLAVE)
      |=> sideband_slave_id == $past(pwdata_in[SLAVE_W-1:0])) // R5
    else $error("sideband slave id write lost");

  // decoded flags
  a_full_power_flag: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    loaded |=> bus_reset_full_power_out == $past(info2[FULL_PWR_BIT])) // R8
    else $error("full power flag wrong");
  a_line_fix_follow: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    loaded |=> line_invalidate_write_fixed_out == $past(info2[LIW_FIX_BIT])) // R9
    else $error("line invalidate flag lags");
  a_phy_type_copy: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    loaded |=> forced_phy_type_out == $past(info3[PHY_LSB +: PHY_W])) // R11
    else $error("forced phy type wrong");
  a_phy_reserved: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    info3[PHY_LSB +: PHY_W] > PHY_LAST_CODE |=> !forced_phy_valid_out) // R11
    else $error("reserved phy code flagged valid");

  // power state
  a_keep_power: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    bus_rst_pulse && !info2[FULL_PWR_BIT] && !wr_hit(wr_access, paddr_in, REG_POWER)
      |=> $stable(power_state)) // R8
    else $error("power state moved without cause");
  a_power_write: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    wr_hit(wr_access, paddr_in, REG_POWER) && !(bus_rst_pulse && info2[FULL_PWR_BIT])
      |=> power_state == $past(pwdata_in[1:0])) // R8
    else $error("power state write lost");

  c_load_done: cover property (@(posedge ref_clk_in) disable iff (!nrst_in) $rose(loaded));
  c_host_write: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
    loaded && wr_access && paddr_in == REG_CORE);
  c_bus_reset: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
    bus_rst_pulse && info2[FULL_PWR_BIT]);
  c_smb_match: cover property (@(posedge ref_clk_in) disable iff (!nrst_in) smb_addr_match_out);
  c_early_drop: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
    !loaded && wr_access && paddr_in == REG_CORE);
endmodule : eeprom_config_word_loader

// ==== src/loader_pkg.sv ====
// Overview of operation
// R1 - The first fetched setup word fills the low half of the core setup word, the second the high half.
// R2 - After every reset both core setup words are fetched with no software action.
// R3 - Once loading is over, software may overwrite the core setup word.
// R4 - After reset the stored option word is copied into the transceiver option mask.
// R5 - The stored address word sets the sideband slave id, and matching sideband addresses are answered.
// R6 - With the header flag set, bit 4 of driver info 2 picks level (0) or pulsed (1) wake signalling.
// R7 - The pulse mode bit is ignored whenever the aux wake header flag (bit 3) is 0.
// R8 - With bit 7 of driver info 2 set, a bus reset forces the power state back to D0.
// R9 - Bit 5 of driver info 2 reads 1 when line invalidate writes work and may be enabled, else 0.
// R10 - The board model code holds hardware config in its upper byte and software revision below.
// R11 - Bits 3:0 of driver info 3 give the forced phy type; codes above 0101 are reserved.
// R12 - The host applies the forced phy type only with auto pick clear and an MII or autoneg select.
// R13 - Loaded registers keep their defaults until the whole fetch ends, then all update at once.
package loader_pkg;
  // apb byte offsets
  localparam logic [7:0] REG_CORE = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_SLAVE = 8'h08;
  localparam logic [7:0] REG_INFO2 = 8'h0C;
  localparam logic [7:0] REG_INFO3 = 8'h10;
  localparam logic [7:0] REG_BOARD = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_POWER = 8'h1C;
  // fetch slots, in fetch order
  localparam int NUM_WORDS = 8;
  localparam int W_CORE_LO = 0;
  localparam int W_CORE_HI = 1;
  localparam int W_INFO2 = 2;
  localparam int W_INFO3 = 3;
  localparam int W_VENDOR = 4;
  localparam int W_MODEL = 5;
  localparam int W_MEDIA = 6;
  localparam int W_SLAVE = 7;
  localparam int SLOT_W = 3;
  // eeprom word addresses of each slot
  localparam logic [7:0] EE_CORE_LO = 8'h0D;
  localparam logic [7:0] EE_CORE_HI = 8'h0E;
  localparam logic [7:0] EE_INFO2 = 8'h0F;
  localparam logic [7:0] EE_INFO3 = 8'h10;
  localparam logic [7:0] EE_VENDOR = 8'h11;
  localparam logic [7:0] EE_MODEL = 8'h12;
  localparam logic [7:0] EE_MEDIA = 8'h13;
  localparam logic [7:0] EE_SLAVE = 8'h14;
  // driver info fields
  localparam int AUX_HDR_BIT = 3;
  localparam int PULSE_BIT = 4;
  localparam int LIW_FIX_BIT = 5;
  localparam int FULL_PWR_BIT = 7;
  localparam int PHY_LSB = 0;
  localparam int PHY_W = 4;
  localparam logic [3:0] PHY_LAST_CODE = 4'h5;
  localparam int SLAVE_W = 7;
  localparam int BYTE_W = 8;
  // hardware defaults before the fetch ends
  localparam logic [31:0] CORE_DEFAULT = 32'h0000_0000;
  localparam logic [15:0] MASK_DEFAULT = 16'h0000;
  localparam logic [6:0] SLAVE_DEFAULT = 7'h00;
  localparam logic [15:0] WORD_DEFAULT = 16'h0000;
  // power states
  localparam logic [1:0] PWR_D0 = 2'h0;
  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_FINISH = 3'b010,
    ST_HOLD = 3'b100
  } fetch_state_type;
  function automatic logic [7:0] ee_word_addr(input logic [SLOT_W-1:0] slot);
    case (slot)
      3'h0: ee_word_addr = EE_CORE_LO;
      3'h1: ee_word_addr = EE_CORE_HI;
      3'h2: ee_word_addr = EE_INFO2;
      3'h3: ee_word_addr = EE_INFO3;
      3'h4: ee_word_addr = EE_VENDOR;
      3'h5: ee_word_addr = EE_MODEL;
      3'h6: ee_word_addr = EE_MEDIA;
      default: ee_word_addr = EE_SLAVE;
    endcase
  endfunction : ee_word_addr
endpackage : loader_pkg
